/* File: brake_pkg.sv */
/*
   Shared constants, register map, state type and helper functions of the
   holding-brake sequencer and deviation guard.
   Assumes a 25 MHz control clock and a 32-bit APB register bus.
*/
`default_nettype none

package brake_pkg;

   // Clock and time base
   localparam int unsigned CLK_PERIOD_NS = 40;
   localparam int unsigned MS_NS         = 1000000;
   localparam int unsigned MS_CYCLES     = MS_NS / CLK_PERIOD_NS;
   localparam logic [15:0] MS_PER_STEP   = 16'h000a;   // 10 ms step

   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_DEV_LIMIT = 16'h335c;
   localparam logic [15:0] IDX_ON_DLY    = 16'h335d;
   localparam logic [15:0] IDX_OFF_DLY   = 16'h335e;
   localparam logic [15:0] IDX_SPD_THR   = 16'h335f;
   localparam logic [15:0] IDX_BRK_WAIT  = 16'h3360;
   localparam logic [15:0] IDX_CTRL      = 16'h3370;
   localparam logic [15:0] IDX_STATUS    = 16'h3371;

   // Reset values
   localparam logic [31:0] RST_DEV_LIMIT = 32'h0280_0000;
   localparam logic [15:0] RST_ON_DLY    = 16'h0000;
   localparam logic [15:0] RST_OFF_DLY   = 16'h0000;
   localparam logic [15:0] RST_SPD_THR   = 16'h0064;
   localparam logic [15:0] RST_BRK_WAIT  = 16'h0032;
   localparam logic        RST_BRAKE_EN  = 1'b1;

   // Legal write ranges
   localparam logic [31:0] DEV_LIMIT_MIN = 32'h0000_0001;
   localparam logic [31:0] DEV_LIMIT_MAX = 32'h0500_0000;
   localparam logic signed [15:0] ON_DLY_MIN = 16'shf830;   // -2000 ms
   localparam logic signed [15:0] ON_DLY_MAX = 16'sh07d0;   // 2000 ms
   localparam logic [15:0] OFF_DLY_MAX   = 16'h01f4;
   localparam logic [15:0] SPD_THR_MIN   = 16'h000a;
   localparam logic [15:0] SPD_THR_MAX   = 16'h0064;
   localparam logic [15:0] BRK_WAIT_MIN  = 16'h000a;
   localparam logic [15:0] BRK_WAIT_MAX  = 16'h0064;

   // Field positions
   localparam int unsigned CTRL_BRAKE_EN_BIT = 0;
   localparam int unsigned ST_ALARM_BIT      = 0;
   localparam int unsigned ST_BRAKE_BIT      = 1;
   localparam int unsigned ST_EXCITE_BIT     = 2;
   localparam int unsigned ST_SERVO_BIT      = 3;
   localparam int unsigned ST_STATE_LSB      = 4;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ON_LEAD, SEQ_RUN, SEQ_OFF} seq_state_e;

   typedef enum logic [2:0] {
      SEL_NONE, SEL_LIMIT, SEL_ON, SEL_OFF, SEL_SPD, SEL_WAIT, SEL_CTRL, SEL_STATUS
   } reg_sel_e;

   // Byte address of a register index
   function automatic logic [15:0] byte_addr(input logic [15:0] idx);
      return {idx[13:0], 2'b00};
   endfunction

   // Register select from a bus address
   function automatic reg_sel_e reg_sel(input logic [15:0] addr);
      if (addr == byte_addr(IDX_DEV_LIMIT)) return SEL_LIMIT;
      else if (addr == byte_addr(IDX_ON_DLY)) return SEL_ON;
      else if (addr == byte_addr(IDX_OFF_DLY)) return SEL_OFF;
      else if (addr == byte_addr(IDX_SPD_THR)) return SEL_SPD;
      else if (addr == byte_addr(IDX_BRK_WAIT)) return SEL_WAIT;
      else if (addr == byte_addr(IDX_CTRL)) return SEL_CTRL;
      else if (addr == byte_addr(IDX_STATUS)) return SEL_STATUS;
      else return SEL_NONE;
   endfunction

   // Ten-millisecond steps to milliseconds; 500 steps still fit 16 bits
   function automatic logic [15:0] steps_to_ms(input logic [15:0] steps);
      return 16'(steps * MS_PER_STEP);
   endfunction

   // Saturating millisecond counter step
   function automatic logic [15:0] sat_inc(input logic [15:0] v);
      return (v == 16'hffff) ? v : 16'(v + 16'h0001);
   endfunction

endpackage

`default_nettype wire

/* File: brake_sequencer_deviation_guard.sv */
/*
   Holding-brake sequencer and position deviation guard of a servo drive,
   with its APB register file.
   Assumes servo_on comes from a pin, while speed and deviation come from
   logic on the same 25 MHz clock. Speed is an unsigned rpm magnitude.
*/
`timescale 1ns/1ps
`default_nettype none

module brake_sequencer_deviation_guard
   import brake_pkg::*;
#(
   parameter int unsigned MS_TICK_CYCLES = MS_CYCLES
) (
   // Clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // APB slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [15:0]        paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // Drive side inputs
   input  wire logic               servo_on,
   input  wire logic [15:0]        motor_speed_rpm,
   input  wire logic signed [31:0] deviation_count,
   // Motor side outputs
   output logic                    brake_release_output,
   output logic                    motor_excite,
   output logic                    deviation_alarm
);

   // Whole block state, registered in one place
   typedef struct packed {
      seq_state_e  st;
      logic [31:0] dev_limit;
      logic [15:0] on_dly;
      logic [15:0] off_dly;
      logic [15:0] spd_thr;
      logic [15:0] brk_wait;
      logic        brake_en;
      logic [31:0] prdata;
      logic        pslverr;
      logic        bk;
      logic        excite;
      logic        alarm;
      logic [15:0] lead_ms;
      logic [15:0] brk_ms;
      logic [15:0] pwr_ms;
   } core_s;

   // Reset image: brake held, power off, default settings
   localparam core_s CORE_RST = '{
      st:        SEQ_IDLE,
      dev_limit: RST_DEV_LIMIT,
      on_dly:    RST_ON_DLY,
      off_dly:   RST_OFF_DLY,
      spd_thr:   RST_SPD_THR,
      brk_wait:  RST_BRK_WAIT,
      brake_en:  RST_BRAKE_EN,
      prdata:    32'h0000_0000,
      pslverr:   1'b0,
      bk:        1'b0,
      excite:    1'b0,
      alarm:     1'b0,
      lead_ms:   16'h0000,
      brk_ms:    16'h0000,
      pwr_ms:    16'h0000
   };

   // State, synchronised pin, tick and decode nets
   core_s       r;
   core_s       n;
   logic        servo_s;
   logic        ms_tick;
   reg_sel_e    sel;
   logic [31:0] dev_mag;
   logic [15:0] lead_target;
   logic [31:0] status_word;

   // Servo-on arrives from a pin, so it is synchronised first
   level_sync u_servo_sync (
      .pclk     (pclk),
      .presetn  (presetn),
      .async_in (servo_on),
      .sync_out (servo_s)
   );

   // Common millisecond base for every brake timer
   ms_tick_gen #(
      .CYCLES (MS_TICK_CYCLES)
   ) u_ms_tick (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (ms_tick)
   );

   // Decode, magnitudes and status word
   assign sel         = reg_sel(paddr);
   assign dev_mag     = deviation_count[31] ? 32'(-deviation_count) : 32'(deviation_count);
   assign lead_target = r.on_dly[15] ? 16'(-r.on_dly) : r.on_dly;

   // Status bits for software; captured at setup like other reads
   always_comb begin
      status_word                    = 32'h0000_0000;
      status_word[ST_ALARM_BIT]      = r.alarm;
      status_word[ST_BRAKE_BIT]      = r.bk;
      status_word[ST_EXCITE_BIT]     = r.excite;
      status_word[ST_SERVO_BIT]      = servo_s;
      status_word[ST_STATE_LSB +: 2] = r.st;
   end

   // Next-state logic of the whole block
   always_comb begin
      n = r;

      // Overflow check runs every cycle; alarm is a level, not latched
      n.alarm = (dev_mag > r.dev_limit);

      // Setup phase: latch read data and the error answer for access
      if (psel && !penable) begin
         n.prdata  = 32'h0000_0000;
         n.pslverr = 1'b0;
         // Range checks; a refused write leaves the register alone
         if (pwrite) begin
            case (sel)
               SEL_LIMIT: begin
                  n.pslverr = (pwdata < DEV_LIMIT_MIN) || (pwdata > DEV_LIMIT_MAX);
               end
               SEL_ON: begin
                  n.pslverr = ($signed(pwdata[15:0]) < ON_DLY_MIN) ||
                              ($signed(pwdata[15:0]) > ON_DLY_MAX);
               end
               SEL_OFF: begin
                  n.pslverr = (pwdata[15:0] > OFF_DLY_MAX);
               end
               SEL_SPD: begin
                  n.pslverr = (pwdata[15:0] < SPD_THR_MIN) || (pwdata[15:0] > SPD_THR_MAX);
               end
               SEL_WAIT: begin
                  n.pslverr = (pwdata[15:0] < BRK_WAIT_MIN) || (pwdata[15:0] > BRK_WAIT_MAX);
               end
               SEL_CTRL: begin
                  n.pslverr = 1'b0;
               end
               default: begin
                  n.pslverr = 1'b1;   // Unmapped or read-only
               end
            endcase
         end else begin
            // Unmapped reads answer zero with an error
            case (sel)
               SEL_LIMIT:  n.prdata = r.dev_limit;
               SEL_ON:     n.prdata = {16'h0000, r.on_dly};
               SEL_OFF:    n.prdata = {16'h0000, r.off_dly};
               SEL_SPD:    n.prdata = {16'h0000, r.spd_thr};
               SEL_WAIT:   n.prdata = {16'h0000, r.brk_wait};
               SEL_CTRL:   n.prdata = {31'h0000_0000, r.brake_en};
               SEL_STATUS: n.prdata = status_word;
               default:    n.pslverr = 1'b1;
            endcase
         end
      end

      // Access phase: write lands here, out-of-range values are dropped
      if (psel && penable && pwrite && !r.pslverr) begin
         case (sel)
            SEL_LIMIT: n.dev_limit = pwdata;
            SEL_ON:    n.on_dly    = pwdata[15:0];
            SEL_OFF:   n.off_dly   = pwdata[15:0];
            SEL_SPD:   n.spd_thr   = pwdata[15:0];
            SEL_WAIT:  n.brk_wait  = pwdata[15:0];
            SEL_CTRL:  n.brake_en  = pwdata[CTRL_BRAKE_EN_BIT];
            default:   n.brake_en  = r.brake_en;
         endcase
      end

      // Brake and excitation sequencing
      case (r.st)
         // Parked: servo-on picks the lead order
         SEQ_IDLE: begin
            n.bk      = 1'b0;
            n.excite  = 1'b0;
            n.lead_ms = 16'h0000;
            if (servo_s) begin
               if (!r.brake_en) begin
                  // Brake output unused: timings ignored, excite directly
                  n.excite = 1'b1;
                  n.st     = SEQ_RUN;
               end else if (r.on_dly == 16'h0000) begin
                  n.bk     = 1'b1;
                  n.excite = 1'b1;
                  n.st     = SEQ_RUN;
               end else if (!r.on_dly[15]) begin
                  n.bk = 1'b1;
                  n.st = SEQ_ON_LEAD;
               end else begin
                  n.excite = 1'b1;
                  n.st     = SEQ_ON_LEAD;
               end
            end
         end

         // Lead counts whole ticks; the first may be short
         SEQ_ON_LEAD: begin
            if (!servo_s) begin
               // Servo dropped during the lead: abandon at once
               n.bk     = 1'b0;
               n.excite = 1'b0;
               n.st     = SEQ_IDLE;
            end else if (ms_tick) begin
               n.lead_ms = sat_inc(r.lead_ms);
               if (sat_inc(r.lead_ms) >= lead_target) begin
                  n.bk     = 1'b1;
                  n.excite = 1'b1;
                  n.st     = SEQ_RUN;
               end
            end
         end

         // Running: servo-off starts both stop timers
         SEQ_RUN: begin
            if (!servo_s) begin
               n.brk_ms = 16'h0000;
               n.pwr_ms = 16'h0000;
               if (!r.brake_en) begin
                  n.bk     = 1'b0;
                  n.excite = 1'b0;
                  n.st     = SEQ_IDLE;
               end else begin
                  n.st = SEQ_OFF;
                  if (motor_speed_rpm == 16'h0000) begin
                     n.bk = 1'b0;
                  end
                  if (r.off_dly == 16'h0000) begin
                     n.excite = 1'b0;
                  end
               end
            end
         end

         // Stopping: brake and power end independently
         SEQ_OFF: begin
            // Both timers run from the servo-off moment in parallel
            if (ms_tick) begin
               n.brk_ms = sat_inc(r.brk_ms);
               n.pwr_ms = sat_inc(r.pwr_ms);
            end
            // Speed or elapsed wait, whichever first
            if (r.bk && ((motor_speed_rpm < r.spd_thr) ||
                         (r.brk_ms > steps_to_ms(r.brk_wait)))) begin
               n.bk = 1'b0;
            end
            if (r.excite && (r.pwr_ms >= steps_to_ms(r.off_dly))) begin
               n.excite = 1'b0;
            end
            // A new servo-on is taken only after the stop has finished
            if (!n.bk && !n.excite) begin
               n.st = SEQ_IDLE;
            end
         end

         // Unused code: fall back to a safe stop
         default: begin
            n.st = SEQ_IDLE;
         end
      endcase
   end

   // One state register; reset holds the brake
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= CORE_RST;
      end else begin
         r <= n;
      end
   end

   // Zero-wait slave; read data was latched in the setup cycle
   assign pready               = 1'b1;
   assign pslverr              = r.pslverr;
   assign prdata               = r.prdata;
   assign brake_release_output = r.bk;
   assign motor_excite         = r.excite;
   assign deviation_alarm      = r.alarm;

endmodule

`default_nettype wire

/* File: bsdg_props.sv */
/* Port checker for the brake sequencer and deviation guard.
   Assumes it is bound to the top module and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module bsdg_props
   import brake_pkg::*;
#(parameter int unsigned MS_TICK_CYCLES = 10) (
   // Clock and reset
   input wire logic               pclk,
   input wire logic               presetn,
   // APB
   input wire logic               psel,
   input wire logic               penable,
   input wire logic               pwrite,
   input wire logic [15:0]        paddr,
   input wire logic [31:0]        pwdata,
   input wire logic [31:0]        prdata,
   input wire logic               pready,
   input wire logic               pslverr,
   // Drive and motor
   input wire logic               servo_on,
   input wire logic [15:0]        motor_speed_rpm,
   input wire logic signed [31:0] deviation_count,
   input wire logic               brake_release_output,
   input wire logic               motor_excite,
   input wire logic               deviation_alarm
);
   localparam int WAIT_MAX = 1003 * MS_TICK_CYCLES + 10;
   typedef struct packed {logic [31:0] lim; logic [15:0] cnt;} chk_s;
   logic        acc;
   logic [31:0] mag;
   chk_s        st_r, st_nxt;
   assign acc = psel && penable && pready;
   assign mag = deviation_count[31] ? $unsigned(-deviation_count) : $unsigned(deviation_count);
   // Shadow of the limit; cycles the brake stays released after servo-off
   always_comb begin
      st_nxt = st_r;
      if (acc && pwrite && paddr == 16'hcd70 && pwdata >= DEV_LIMIT_MIN && pwdata <= DEV_LIMIT_MAX)
         st_nxt.lim = pwdata;
      st_nxt.cnt = (servo_on || !brake_release_output) ? 16'h0000 : st_r.cnt + 16'h0001;
   end
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) st_r <= '{lim: RST_DEV_LIMIT, cnt: 16'h0000};
      else st_r <= st_nxt;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_const: assert property (pready) else $error("pready low");
   a_unmapped_err:
      assert property (acc && paddr == 16'h0000 |-> pslverr && (pwrite || prdata == 32'h0))
      else $error("unmapped access not refused");
   a_limit_range:
      assert property (acc && pwrite && paddr == 16'hcd70 && (pwdata == 32'h0 || pwdata > DEV_LIMIT_MAX) |-> pslverr)
      else $error("limit out of range accepted");
   a_alarm_level:
      assert property ($past(presetn) |-> deviation_alarm == ($past(mag) > $past(st_r.lim)))
      else $error("alarm does not follow deviation");
   a_off_still:
      assert property ($fell(servo_on) && motor_speed_rpm == 16'h0000 && brake_release_output
                       |-> ##[1:5] !brake_release_output)
      else $error("brake late on stationary stop");
   a_brake_cause:
      assert property ($fell(brake_release_output) |-> !$past(servo_on, 2) || !$past(servo_on, 3))
      else $error("brake applied without servo-off");
   a_excite_cause:
      assert property ($rose(motor_excite) |-> $past(servo_on, 2) || $past(servo_on, 3))
      else $error("excitation without servo-on");
   a_wait_bound: assert property (st_r.cnt <= WAIT_MAX) else $error("brake wait overrun");
   c_alarm: cover property ($rose(deviation_alarm));
   c_moving_stop: cover property ($fell(brake_release_output) && motor_speed_rpm != 16'h0000);
   c_refused: cover property (acc && pslverr);
endmodule
bind brake_sequencer_deviation_guard bsdg_props #(.MS_TICK_CYCLES(MS_TICK_CYCLES)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .servo_on(servo_on), .motor_speed_rpm(motor_speed_rpm), .deviation_count(deviation_count),
   .brake_release_output(brake_release_output), .motor_excite(motor_excite),
   .deviation_alarm(deviation_alarm));
`default_nettype wire

/* File: level_sync.sv */
/*
   Two-stage synchroniser for one level from outside the clock domain.
   Assumes the input changes slowly compared to the clock.
*/
`timescale 1ns/1ps
`default_nettype none

module level_sync (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Level in and out
   input  wire logic async_in,
   output logic      sync_out
);

   typedef struct packed {
      logic meta;
      logic stable;
   } sync_s;

   sync_s r, n;

   // First stage feeds only the second
   always_comb begin
      n        = r;
      n.meta   = async_in;
      n.stable = r.meta;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign sync_out = r.stable;

endmodule

`default_nettype wire

/* File: motor_model.sv */
/* Servo motor with holding brake, seen from the drive.
   Assumes the bench sets the target speed and how fast it coasts. */
`timescale 1ns/1ps
`default_nettype none
module motor_model (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // From the drive
   input  wire logic        motor_excite,
   input  wire logic        brake_release_output,
   // Bench controls
   input  wire logic [15:0] target_rpm,
   input  wire logic        slow_coast,
   // To the drive
   output logic      [15:0] motor_speed_rpm
);
   typedef struct packed {logic [15:0] spd; logic [2:0] div;} mot_s;
   mot_s st_r, st_nxt;
   assign motor_speed_rpm = st_r.spd;
   // Brake holds the shaft; power spins it up; else it coasts down
   always_comb begin
      st_nxt = st_r;
      st_nxt.div = st_r.div + 3'h1;
      if (!brake_release_output)
         st_nxt.spd = 16'h0000;
      else if (motor_excite)
         st_nxt.spd = (st_r.spd + 16'h000a > target_rpm) ? target_rpm : st_r.spd + 16'h000a;
      else if (st_r.spd != 16'h0000 && (!slow_coast || st_r.div == 3'h0))
         st_nxt.spd = st_r.spd - 16'h0001;
   end
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn) st_r <= '0;
      else st_r <= st_nxt;
endmodule
`default_nettype wire

/* File: ms_tick_gen.sv */
/*
   Millisecond time base: one-cycle pulse every CYCLES clocks.
   Assumes a free-running control clock.
*/
`timescale 1ns/1ps
`default_nettype none

module ms_tick_gen #(
   parameter int unsigned CYCLES = 25000
) (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // One pulse per millisecond
   output logic      tick
);

   typedef struct packed {
      logic [31:0] cnt;
      logic        tick;
   } tick_s;

   tick_s r, n;

   // Wrap counter; pulse registered so it is glitch free
   always_comb begin
      n      = r;
      n.tick = 1'b0;
      if (r.cnt >= 32'(CYCLES - 1)) begin
         n.cnt  = '0;
         n.tick = 1'b1;
      end else begin
         n.cnt = 32'(r.cnt + 32'h1);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign tick = r.tick;

endmodule

`default_nettype wire

/* File: testbench.sv */
/* Self-checking bench for the brake sequencer and deviation guard.
   Assumes a 40 ns pclk and a 10-cycle millisecond in simulation. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %s exp %0h got %0h", nm, e, g); end end
module testbench;
   localparam int MS = 10;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, servo_on, slow_coast;
   logic        brake_release_output, motor_excite, deviation_alarm;
   logic [15:0] paddr, motor_speed_rpm, target_rpm;
   logic [31:0] pwdata, prdata;
   logic signed [31:0] deviation_count;
   logic [33:0] note;
   logic [33:0] exp_q[$];
   int          num_errors, n_checks, seed, c, c2, lim, dev;
   logic [15:0] ra[6] = '{16'hcd70, 16'hcd74, 16'hcd78, 16'hcd7c, 16'hcd80, 16'hcdc0};
   logic [31:0] rv[6] = '{32'h0280_0000, 32'h0, 32'h0, 32'h64, 32'h32, 32'h1};
   logic [15:0] wa[11] = '{16'hcd70, 16'hcd70, 16'hcd70, 16'hcd74, 16'hcd74, 16'hcd78, 16'hcd7c, 16'hcd80,
                           16'hcd80, 16'hcdc4, 16'h0000};
   logic [31:0] wd[11] = '{32'h0, 32'h0500_0001, 32'h0500_0000, 32'h7d1, 32'hf830, 32'h1f5, 32'h9, 32'h65,
                           32'ha, 32'h0, 32'h0};
   logic        we[11] = '{1, 1, 0, 1, 0, 1, 1, 1, 0, 1, 1};

   brake_sequencer_deviation_guard #(.MS_TICK_CYCLES(MS)) DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .servo_on(servo_on),
      .motor_speed_rpm(motor_speed_rpm), .deviation_count(deviation_count),
      .brake_release_output(brake_release_output), .motor_excite(motor_excite), .deviation_alarm(deviation_alarm));
   motor_model u_motor (.pclk(pclk), .presetn(presetn), .motor_excite(motor_excite),
      .brake_release_output(brake_release_output), .target_rpm(target_rpm), .slow_coast(slow_coast),
      .motor_speed_rpm(motor_speed_rpm));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic final_report();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // One APB transfer; the expected answer is queued for the monitor
   task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d, ed, input logic ee);
      exp_q.push_back({w, ed, ee});
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      {psel, penable} <= 2'b00;
   endtask

   // Scoreboard: oldest note taken when a transfer completes
   always @(posedge pclk)
      if (psel && penable && pready) begin
         note = exp_q.pop_front();
         `CHK("pslverr", note[0], pslverr)
         if (!note[33]) `CHK("prdata", note[32:1], prdata)
      end

   // Edges until an output reaches a level; looks just after the edge
   task automatic wait_out(input bit ex, input logic lvl, output int cyc);
      cyc = 0;
      do begin
         @(posedge pclk);
         #1;
         cyc++;
      end while ((ex ? motor_excite : brake_release_output) !== lvl && cyc < 20000);
      `CHK("wait_level", lvl, ex ? motor_excite : brake_release_output)
   endtask

   task automatic servo(input logic v);
      @(posedge pclk);
      servo_on <= v;
   endtask

   task automatic on_seq(input int d);
      apb(1'b1, 16'hcd74, 32'(d) & 32'h0000_ffff, 32'h0, 1'b0);
      servo(1'b1);
      wait_out(d < 0, 1'b1, c);
      `CHK("lead_order", 1'b0, d < 0 ? brake_release_output : motor_excite)
      wait_out(d >= 0, 1'b1, c);
      d = (d < 0) ? -d : d;
      `CHK("lead_time", 1'b1, c >= MS * (d - 1) && c <= MS * d + 2)
   endtask

   task automatic off_still(input int steps);
      apb(1'b1, 16'hcd78, 32'(steps), 32'h0, 1'b0);
      servo(1'b0);
      wait_out(1'b0, 1'b0, c);
      `CHK("brake_at_off", 1'b1, c <= 4)
      wait_out(1'b1, 1'b0, c2);
      `CHK("power_delay", 1'b1, c + c2 >= steps * 10 * MS - MS && c + c2 <= steps * 10 * MS + 4)
   endtask

   // Spin up, cut power, time the brake against speed and wait
   task automatic coast(input logic slow);
      apb(1'b1, 16'hcd74, 32'h0, 32'h0, 1'b0);
      @(posedge pclk);
      servo_on <= 1'b1;
      target_rpm <= 16'd500;
      slow_coast <= slow;
      repeat (100) @(posedge pclk);
      servo_on <= 1'b0;
      wait_out(1'b0, 1'b0, c);
      if (slow) begin
         `CHK("wait_time", 1'b1, c >= 995 && c <= 1015 && motor_speed_rpm >= 16'd50)
      end else begin
         `CHK("speed_thr", 1'b1, c >= 445 && c <= 465 && motor_speed_rpm < 16'd50)
      end
   endtask

   initial begin
      repeat (40000) @(posedge pclk);
      num_errors++;
      final_report();
   end

   initial begin
      {presetn, psel, penable, pwrite, servo_on, slow_coast} = 6'b0;
      {paddr, target_rpm, pwdata} = 64'h0;
      deviation_count = 32'sh0;
      seed = 40245;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      foreach (ra[i]) apb(1'b0, ra[i], 32'h0, rv[i], 1'b0);
      foreach (wa[i]) apb(1'b1, wa[i], wd[i], 32'h0, we[i]);
      apb(1'b0, 16'hcd70, 32'h0, 32'h0500_0000, 1'b0);
      apb(1'b0, 16'hcd74, 32'h0, 32'h0000_f830, 1'b0);
      apb(1'b0, 16'h0000, 32'h0, 32'h0, 1'b1);
      // Random deviations about a random limit, edges first
      lim = 1 + int'($unsigned($random(seed)) % 1000);
      apb(1'b1, 16'hcd70, 32'(lim), 32'h0, 1'b0);
      for (int i = 0; i < 24; i++) begin
         dev = (i == 0) ? lim : (i == 1) ? -(lim + 1) : $random(seed) % 2000;
         @(posedge pclk);
         deviation_count <= dev;
         repeat (2) @(posedge pclk);
         #1;
         `CHK("alarm", ((dev < 0 ? -dev : dev) > lim), deviation_alarm)
      end
      on_seq(3);
      // Status while running: state run, servo seen, power on, brake released
      apb(1'b0, 16'hcdc4, 32'h0, 32'h2e | 32'((dev < 0 ? -dev : dev) > lim), 1'b0);
      off_still(2);
      on_seq(-3);
      off_still(0);
      apb(1'b1, 16'hcd7c, 32'd50, 32'h0, 1'b0);
      coast(1'b0);
      coast(1'b1);
      // Brake function off: power follows servo-on, brake stays held
      apb(1'b1, 16'hcdc0, 32'h0, 32'h0, 1'b0);
      apb(1'b1, 16'hcd74, 32'd3, 32'h0, 1'b0);
      servo(1'b1);
      wait_out(1'b1, 1'b1, c);
      `CHK("no_brake_fn", 1'b1, c <= 4 && brake_release_output === 1'b0)
      servo(1'b0);
      wait_out(1'b1, 1'b0, c);
      `CHK("queue_empty", 0, exp_q.size())
      final_report();
   end
endmodule
`default_nettype wire
